//--- hdl/status_pkg.sv
package status_pkg;

  // ==========================================================================
  // Timing constants
  // ==========================================================================
  localparam int unsigned CLK_HZ          = 100_000_000;
  // Lamp test time in milliseconds, a longest time, so it rounds down.
  localparam int unsigned LAMP_MS         = 1000;
  localparam int unsigned LAMP_CYC        = CLK_HZ / 1000 * LAMP_MS;
  // Low-supply hysteresis time in milliseconds.
  localparam int unsigned HYST_MS         = 5000;
  localparam longint unsigned HYST_CYC    = 64'(CLK_HZ) / 1000 * HYST_MS;
  // Default prescaler: one flash step every 10 ms.
  localparam int unsigned PRESC_DEF       = 1_000_000;
  // Flash pattern is 10 steps; green lit for 2 steps gives 20%.
  localparam logic [3:0]  FLASH_STEPS     = 4'hA;
  localparam logic [3:0]  GREEN_STEPS     = 4'h2;
  localparam logic [3:0]  SLOW_HALF       = 4'h5;

  // ==========================================================================
  // Magnet spacing window in millimetres
  // ==========================================================================
  localparam logic [15:0] CLOSE_MIN_MM    = 16'h0019;
  localparam logic [15:0] CLOSE_MAX_MM    = 16'h0032;

  // ==========================================================================
  // Error codes reported on the bus variant
  // ==========================================================================
  localparam logic [15:0] ERR_NONE        = 16'h0000;
  localparam logic [15:0] ERR_CLOSE       = 16'h0100;
  localparam logic [15:0] ERR_LOW_SUPPLY  = 16'h0020;
  localparam logic [15:0] ERR_HIGH_TEMP   = 16'h0040;
  localparam logic [15:0] ERR_RANGE       = 16'h0003;
  localparam logic [15:0] ERR_MISSING     = 16'h0004;

  // Phase of the indicator sequencer.
  typedef enum logic [0:0] {
    PH_LAMP = 1'b0,
    PH_RUN  = 1'b1
  } phase_type;

endpackage : status_pkg

//--- hdl/flash_if.sv
`timescale 1ns/10ps
// Flash timing signals from the pattern generator to the indicator logic.
interface flash_if;
  logic       step;
  logic [3:0] phase;

  modport gen (output step, output phase);
  modport use_side (input step, input phase);
endinterface : flash_if

//--- hdl/flash_gen.sv
`timescale 1ns/10ps
// ============================================================================
// Flash pattern generator
// ============================================================================
module flash_gen #(
  parameter int unsigned PRESC_W = 24
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic [PRESC_W-1:0] presc,
  flash_if.gen                    fl
);

  // Refuses prescaler widths that the counter cannot serve.
  if (PRESC_W < 2 || PRESC_W > 32) begin : g_bad_width
    $error("PRESC_W out of range");
  end

  typedef struct packed {
    logic [PRESC_W-1:0] cnt;
    logic [3:0]         phase;
    logic               step;
  } gen_state_type;

  gen_state_type s_q;
  gen_state_type s_d;

  // Counts prescaler ticks and steps a ten-slot phase counter.
  // programmable prescaler
  always_comb begin
    s_d      = s_q;
    s_d.step = 1'b0;
    if (s_q.cnt >= presc - PRESC_W'(1)) begin
      s_d.cnt  = '0;
      s_d.step = 1'b1;
      s_d.phase = (s_q.phase == status_pkg::FLASH_STEPS - 4'h1) ? 4'h0 : s_q.phase + 4'h1;
    end else begin
      s_d.cnt = s_q.cnt + PRESC_W'(1);
    end
  end

  // Registers the generator state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign fl.step  = s_q.step;
  assign fl.phase = s_q.phase;

  property p_phase_range;
    @(posedge clk) disable iff (rst) s_q.phase < status_pkg::FLASH_STEPS;
  endproperty
  a_phase_range: assert property (p_phase_range) else $error("flash phase out of range");

endmodule : flash_gen

//--- hdl/status_ind.sv
`timescale 1ns/10ps
module status_ind #(
  parameter int unsigned          PRESC_W  = 24,
  parameter longint unsigned      HYST_CYC = status_pkg::HYST_CYC,
  parameter int unsigned          LAMP_CYC = status_pkg::LAMP_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               can_variant,
  input  wire logic [PRESC_W-1:0] presc,
  input  wire logic               magnet_missing,
  input  wire logic               out_of_range,
  input  wire logic               bad_count,
  input  wire logic               two_magnets,
  input  wire logic [15:0]        spacing_mm,
  input  wire logic               high_temp,
  input  wire logic               supply_low,
  input  wire logic               flash_fault,
  output logic                    led_green,
  output logic                    led_red,
  output logic                    pos_valid,
  output logic                    force_high,
  output logic                    force_low,
  output logic [15:0]             err_code
);

  // Refuses cycle counts that the counters cannot serve.
  if (HYST_CYC < 2 || LAMP_CYC < 2) begin : g_bad_counts
    $error("counts too short");
  end

  flash_if fl ();

  // ==========================================================================
  // Flash timing
  // ==========================================================================
  flash_gen #(
    .PRESC_W (PRESC_W)
  ) u_flash (
    .clk   (clk),
    .rst   (rst),
    .presc (presc),
    .fl    (fl)
  );

  typedef struct packed {
    status_pkg::phase_type ph;
    logic [31:0]           lamp_cnt;
    logic [63:0]           hyst_cnt;
    logic                  low_filt;
    logic                  green;
    logic                  red;
    logic                  valid;
    logic                  hi;
    logic                  lo;
    logic [15:0]           code;
  } ind_state_type;

  ind_state_type s_q;
  ind_state_type s_d;

  logic close_hit;
  logic flash20;
  logic slow_on;
  logic half_on;

  // Decodes spacing and the flash slots.
  // spacing window
  assign close_hit = two_magnets && spacing_mm >= status_pkg::CLOSE_MIN_MM
                     && spacing_mm <= status_pkg::CLOSE_MAX_MM;
  assign flash20   = fl.phase < status_pkg::GREEN_STEPS;
  assign slow_on   = fl.phase < status_pkg::SLOW_HALF;
  assign half_on   = fl.phase < status_pkg::SLOW_HALF;

  // ==========================================================================
  // Indicator and output decision
  // ==========================================================================
  always_comb begin
    s_d = s_q;
    if (supply_low != s_q.low_filt) begin
      if (s_q.hyst_cnt >= HYST_CYC - 64'd1) begin
        s_d.low_filt = supply_low;
        s_d.hyst_cnt = '0;
      end else begin
        s_d.hyst_cnt = s_q.hyst_cnt + 64'd1;
      end
    end else begin
      s_d.hyst_cnt = '0;
    end
    case (s_q.ph)
      status_pkg::PH_LAMP: begin
        s_d.green = 1'b1;
        s_d.red   = 1'b1;
        s_d.valid = 1'b0;
        s_d.hi    = 1'b0;
        s_d.lo    = 1'b0;
        s_d.code  = status_pkg::ERR_NONE;
        if (s_q.lamp_cnt >= LAMP_CYC - 32'd1) begin
          s_d.ph = status_pkg::PH_RUN;
        end else begin
          s_d.lamp_cnt = s_q.lamp_cnt + 32'd1;
        end
      end
      status_pkg::PH_RUN: begin
        s_d.green = 1'b1;
        s_d.red   = 1'b0;
        s_d.valid = 1'b1;
        s_d.hi    = 1'b0;
        s_d.lo    = 1'b0;
        s_d.code  = status_pkg::ERR_NONE;
        if (can_variant) begin
          if (flash_fault) begin
            s_d.green = 1'b0;
            s_d.red   = half_on;
            s_d.valid = 1'b0;
          end else if (magnet_missing || out_of_range) begin
            s_d.green = flash20;
            s_d.red   = ~flash20;
            s_d.valid = 1'b0;
            s_d.code  = magnet_missing ? status_pkg::ERR_MISSING : status_pkg::ERR_RANGE;
          end else if (close_hit) begin
            s_d.green = flash20;
            s_d.red   = ~flash20;
            s_d.code  = status_pkg::ERR_CLOSE;
          end else if (s_q.low_filt) begin
            s_d.green = flash20;
            s_d.red   = ~flash20;
            s_d.code  = status_pkg::ERR_LOW_SUPPLY;
          end else if (high_temp) begin
            s_d.green = flash20;
            s_d.red   = ~flash20;
            s_d.code  = status_pkg::ERR_HIGH_TEMP;
          end else if (bad_count) begin
            s_d.green = flash20;
            s_d.red   = ~flash20;
          end
        end else begin
          if (flash_fault) begin
            s_d.green = half_on;
            s_d.red   = half_on;
            s_d.valid = 1'b0;
            s_d.hi    = 1'b1;
          end else if (magnet_missing || out_of_range) begin
            s_d.green = 1'b0;
            s_d.red   = 1'b1;
            s_d.valid = 1'b0;
            s_d.hi    = 1'b1;
          end else if (s_q.low_filt) begin
            s_d.green = 1'b0;
            s_d.red   = slow_on;
            s_d.valid = 1'b0;
            s_d.lo    = 1'b1;
          end else if (bad_count) begin
            s_d.green = 1'b0;
            s_d.red   = 1'b1;
          end else if (high_temp) begin
            s_d.green = 1'b0;
            s_d.red   = slow_on;
          end
        end
      end
      default: begin
        s_d.ph = status_pkg::PH_LAMP;
      end
    endcase
  end

  // Registers all state; outputs come straight from these flops.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign led_green  = s_q.green;
  assign led_red    = s_q.red;
  assign pos_valid  = s_q.valid;
  assign force_high = s_q.hi;
  assign force_low  = s_q.lo;
  assign err_code   = s_q.code;

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_lamp;
    @(posedge clk) disable iff (rst)
      (s_q.ph == status_pkg::PH_RUN) |=> (s_q.ph == status_pkg::PH_RUN);
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp test re-entered");

  property p_missing;
    @(posedge clk) disable iff (rst)
      (s_q.ph == status_pkg::PH_RUN && !can_variant && !flash_fault && magnet_missing)
      |=> (force_high && led_red && !led_green);
  endproperty
  a_missing: assert property (p_missing) else $error("missing magnet not shown");

  property p_count;
    @(posedge clk) disable iff (rst)
      (s_q.ph == status_pkg::PH_RUN && !can_variant && bad_count && !flash_fault
       && !magnet_missing && !out_of_range && !s_q.low_filt)
      |=> (pos_valid && led_red && !led_green);
  endproperty
  a_count: assert property (p_count) else $error("bad count indication wrong");

  property p_low;
    @(posedge clk) disable iff (rst)
      force_low |-> (!$past(can_variant) && $past(s_q.low_filt) && !led_green);
  endproperty
  a_low: assert property (p_low) else $error("forced low without filtered supply");

  property p_hyst;
    @(posedge clk) disable iff (rst)
      $changed(s_q.low_filt) |-> ($past(supply_low) == s_q.low_filt)
                                 && ($past(s_q.hyst_cnt) == HYST_CYC - 64'd1);
  endproperty
  a_hyst: assert property (p_hyst) else $error("filter changed wrongly");

  property p_normal;
    @(posedge clk) disable iff (rst)
      (s_q.ph == status_pkg::PH_RUN && can_variant && !flash_fault && !magnet_missing
       && !out_of_range && !close_hit && !s_q.low_filt && !high_temp && !bad_count)
      |=> (led_green && !led_red && pos_valid && err_code == 16'h0000);
  endproperty
  a_normal: assert property (p_normal) else $error("normal state wrong");

  property p_close;
    @(posedge clk) disable iff (rst)
      (s_q.ph == status_pkg::PH_RUN && can_variant && close_hit && !flash_fault
       && !magnet_missing && !out_of_range) |=> (err_code == 16'h0100 && pos_valid);
  endproperty
  a_close: assert property (p_close) else $error("close magnets not reported");

  property p_supply;
    @(posedge clk) disable iff (rst)
      (err_code == 16'h0020) |-> (pos_valid && (led_green != led_red));
  endproperty
  a_supply: assert property (p_supply) else $error("low supply code inconsistent");

  property p_sev;
    @(posedge clk) disable iff (rst)
      (s_q.ph == status_pkg::PH_RUN && magnet_missing) |=> !pos_valid;
  endproperty
  a_sev: assert property (p_sev) else $error("invalidating fault not first");

  property p_step;
    @(posedge clk) disable iff (rst)
      fl.step |-> $changed(fl.phase);
  endproperty
  a_step: assert property (p_step) else $error("flash step without phase change");

endmodule : status_ind

//--- verif/ctrl_model.sv
`timescale 1ns/10ps
// ============================================================================
// Machine controller model
// ============================================================================
module ctrl_model (
  input  wire logic        clk,
  input  wire logic        clear,
  input  wire logic        led_green,
  input  wire logic        led_red,
  output logic [15:0]      green_cnt,
  output logic [15:0]      red_cnt
);
  // Counts lit cycles of each indicator, so duty patterns can be judged.
  always_ff @(posedge clk) begin
    if (clear) begin
      green_cnt <= 16'h0000;
      red_cnt   <= 16'h0000;
    end else begin
      green_cnt <= green_cnt + 16'(led_green);
      red_cnt   <= red_cnt + 16'(led_red);
    end
  end
endmodule : ctrl_model

//--- verif/encoder_status_indicator_bench.sv
`timescale 1ns/10ps
// ============================================================================
// Bench for the status indicator
// ============================================================================
module encoder_status_indicator_bench;
  logic        clk, rst, can_variant, clear;
  logic [23:0] presc;
  logic        magnet_missing, out_of_range, bad_count, two_magnets;
  logic        high_temp, supply_low, flash_fault;
  logic [15:0] spacing_mm, err_code, green_cnt, red_cnt;
  logic        led_green, led_red, pos_valid, force_high, force_low;
  int          error_cnt = 0;
  int          n_checks  = 0;

  status_ind #(.PRESC_W(24), .HYST_CYC(64'h32), .LAMP_CYC(32'h14)) uut (
    .clk(clk), .rst(rst), .can_variant(can_variant), .presc(presc),
    .magnet_missing(magnet_missing), .out_of_range(out_of_range),
    .bad_count(bad_count), .two_magnets(two_magnets), .spacing_mm(spacing_mm),
    .high_temp(high_temp), .supply_low(supply_low), .flash_fault(flash_fault),
    .led_green(led_green), .led_red(led_red), .pos_valid(pos_valid),
    .force_high(force_high), .force_low(force_low), .err_code(err_code));

  ctrl_model partner (.clk(clk), .clear(clear), .led_green(led_green),
    .led_red(led_red), .green_cnt(green_cnt), .red_cnt(red_cnt));

  // Free running 100 MHz clock.
  always #5 clk = ~clk;

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Clears all conditions and lets the supply filter settle.
  task idle;
    {magnet_missing, out_of_range, bad_count, two_magnets} = 4'h0;
    {high_temp, supply_low, flash_fault} = 3'h0;
    cyc(70);
  endtask : idle

  // Counts lit cycles over n clock edges.
  task measure(input int n);
    clear = 1'b1;
    cyc(1);
    clear = 1'b0;
    cyc(n);
  endtask : measure

  task t_lamp;
    cyc(3);
    check("lamp green", led_green, 1'b1);
    check("lamp red", led_red, 1'b1);
    cyc(17);
    check("lamp last", led_red, 1'b1);
    cyc(1);
    check("run red", led_red, 1'b0);
    cyc(4);
    check("run green", led_green, 1'b1);
    check("run valid", pos_valid, 1'b1);
    check("run code", err_code, 16'h0000);
    $display("test lamp done");
  endtask : t_lamp

  task t_analog;
    can_variant = 1'b0;
    magnet_missing = 1'b1;
    cyc(3);
    check("miss green", led_green, 1'b0);
    check("miss red", led_red, 1'b1);
    check("miss high", force_high, 1'b1);
    magnet_missing = 1'b0;
    out_of_range = 1'b1;
    cyc(3);
    check("range high", force_high, 1'b1);
    check("range red", led_red, 1'b1);
    out_of_range = 1'b0;
    bad_count = 1'b1;
    cyc(3);
    check("count red", led_red, 1'b1);
    check("count green", led_green, 1'b0);
    check("count valid", pos_valid, 1'b1);
    check("count high", force_high, 1'b0);
    idle();
    $display("test analog done");
  endtask : t_analog

  task t_low_analog;
    supply_low = 1'b1;
    cyc(30);
    check("filter entry", force_low, 1'b0);
    cyc(30);
    check("low forced", force_low, 1'b1);
    check("low green", led_green, 1'b0);
    measure(40);
    check("low red duty", red_cnt, 16'h0014);
    supply_low = 1'b0;
    cyc(30);
    check("filter exit", force_low, 1'b1);
    cyc(30);
    check("low released", force_low, 1'b0);
    idle();
    $display("test low supply analog done");
  endtask : t_low_analog

  task t_close;
    logic [15:0] sp [3];
    logic [15:0] ex [3];
    sp = '{16'h0019, 16'h0032, 16'h0033};
    ex = '{16'h0100, 16'h0100, 16'h0000};
    can_variant = 1'b1;
    two_magnets = 1'b1;
    for (int i = 0; i < 3; i++) begin
      spacing_mm = sp[i];
      cyc(3);
      check("close code", err_code, ex[i]);
      check("close valid", pos_valid, 1'b1);
    end
    spacing_mm = 16'h0028;
    cyc(3);
    measure(40);
    check("close green", green_cnt, 16'h0008);
    check("close red", red_cnt, 16'h0020);
    presc = 24'h2;
    cyc(3);
    measure(20);
    check("presc green", green_cnt, 16'h0004);
    presc = 24'h4;
    idle();
    $display("test close magnets done");
  endtask : t_close

  task t_severity;
    supply_low = 1'b1;
    cyc(60);
    check("can low code", err_code, 16'h0020);
    check("can low valid", pos_valid, 1'b1);
    measure(40);
    check("can low green", green_cnt, 16'h0008);
    high_temp = 1'b1;
    cyc(3);
    check("low over temp", err_code, 16'h0020);
    two_magnets = 1'b1;
    spacing_mm = 16'h001E;
    cyc(3);
    check("close over low", err_code, 16'h0100);
    out_of_range = 1'b1;
    cyc(3);
    check("range first", err_code, 16'h0003);
    magnet_missing = 1'b1;
    out_of_range = 1'b0;
    cyc(3);
    check("missing first", err_code, 16'h0004);
    idle();
    can_variant = 1'b0;
    flash_fault = 1'b1;
    bad_count = 1'b1;
    cyc(3);
    check("fault high", force_high, 1'b1);
    measure(40);
    check("fault green", green_cnt, 16'h0014);
    check("fault red", red_cnt, 16'h0014);
    idle();
    $display("test severity done");
  endtask : t_severity

  // Single warnings and faults that the severity test never shows alone.
  task t_warnings;
    can_variant = 1'b1;
    high_temp = 1'b1;
    cyc(3);
    check("temp code", err_code, 16'h0040);
    check("temp valid", pos_valid, 1'b1);
    high_temp = 1'b0;
    bad_count = 1'b1;
    cyc(3);
    check("can count code", err_code, 16'h0000);
    check("can count valid", pos_valid, 1'b1);
    measure(40);
    check("can count green", green_cnt, 16'h0008);
    bad_count = 1'b0;
    flash_fault = 1'b1;
    cyc(3);
    check("can fault valid", pos_valid, 1'b0);
    measure(40);
    check("can fault green", green_cnt, 16'h0000);
    check("can fault red", red_cnt, 16'h0014);
    flash_fault = 1'b0;
    can_variant = 1'b0;
    high_temp = 1'b1;
    cyc(3);
    check("analog temp valid", pos_valid, 1'b1);
    measure(40);
    check("analog temp green", green_cnt, 16'h0000);
    check("analog temp red", red_cnt, 16'h0014);
    idle();
    $display("test warnings done");
  endtask : t_warnings

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // Watchdog cuts a hung run short.
  initial begin
    #500000;
    error_cnt++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    clear = 1'b0;
    can_variant = 1'b1;
    presc = 24'h4;
    spacing_mm = 16'h0064;
    {magnet_missing, out_of_range, bad_count, two_magnets} = 4'h0;
    {high_temp, supply_low, flash_fault} = 3'h0;
    cyc(6);
    rst = 1'b0;
    t_lamp();
    t_analog();
    t_low_analog();
    t_close();
    t_severity();
    t_warnings();
    end_of_test();
  end
endmodule : encoder_status_indicator_bench
